// >>> logic/acmst_map.vh
// register map, field positions and timing constants of the clock monitor
`ifndef ACMST_MAP_VH
`define ACMST_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACMST_IDX_LIVE 8'h5e
`define ACMST_IDX_LATCH 8'h5f
`define ACMST_IDX_CTRL 8'h60
`define ACMST_IDX_ISTAT 8'h61
`define ACMST_IDX_IMASK 8'h62
`define ACMST_AW 12
`define ACMST_IDX_HI 9
`define ACMST_IDX_LO 2

// ----------------------------------------------------------------
// live status bits
// ----------------------------------------------------------------
`define ACMST_LV_MCLK_HALT 6
`define ACMST_LV_PLL_UNLOCK 5
`define ACMST_LV_ABSENT 4
`define ACMST_LV_COMBO 3
`define ACMST_LV_MCLK_INV 2
`define ACMST_LV_SCLK_INV 1
`define ACMST_LV_SR_INV 0

// ----------------------------------------------------------------
// latched flag bits (interrupt status and mask share the layout)
// ----------------------------------------------------------------
`define ACMST_LT_HALT 4
`define ACMST_LT_MISSING 2
`define ACMST_LT_RESYNC 1
`define ACMST_LT_ERROR 0

// ----------------------------------------------------------------
// control bits and reset values
// ----------------------------------------------------------------
`define ACMST_CT_ERR_IGNORE 0
`define ACMST_CT_PLL_EN 1
`define ACMST_CTRL_RST 8'h02
`define ACMST_ZERO8 8'h00
`define ACMST_RESP_OKAY 2'b00
`define ACMST_RESP_SLVERR 2'b10

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACMST_CLK_NS 40
`define ACMST_MCLK_HALT_NS 2000
`define ACMST_SCLK_HALT_NS 4000
`define ACMST_LR_HALT_NS 100000
`define ACMST_FRAME_MIN_NS 10000
`define ACMST_FRAME_MAX_NS 32000
`define ACMST_RESYNC_FRAMES 3'h4
`define ACMST_LRLOW_MAX_BAD 10'h005
`define ACMST_SCLK_RATIO_MIN 10'h020
`define ACMST_SCLK_RATIO_MAX 10'h100

`endif

// >>> logic/acmst_edge_watch.v
// two-stage synchroniser, edge finder and halt timeout for one clock pin
module acmst_edge_watch #(
    parameter [12:0] HALT_CYC = 13'h0032
) (
    input wire aclk,
    input wire aresetn,
    input wire pin_in,
    output wire level,
    output wire rise,
    output wire fall,
    output wire halted
);
    reg sync_a_reg;
    reg sync_b_reg;
    reg prev_reg;
    reg [12:0] idle_reg;
    reg halted_reg;

    assign level = sync_b_reg;
    assign rise = sync_b_reg & ~prev_reg;
    assign fall = ~sync_b_reg & prev_reg;
    assign halted = halted_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a_reg <= 1'b0;
            sync_b_reg <= 1'b0;
            prev_reg <= 1'b0;
            idle_reg <= 13'h0000;
            halted_reg <= 1'b1;
        end
        else
        begin
            sync_a_reg <= pin_in;
            sync_b_reg <= sync_a_reg;
            prev_reg <= sync_b_reg;
            if (sync_b_reg != prev_reg)
            begin
                idle_reg <= 13'h0000;
                halted_reg <= 1'b0;
            end
            else if (idle_reg >= HALT_CYC)
                halted_reg <= 1'b1;
            else
                idle_reg <= idle_reg + 13'h0001;
        end
    end
endmodule

// >>> logic/acmst_sticky.v
// vector of sticky flags; a set in the clearing cycle wins
module acmst_sticky #(
    parameter W = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [W-1:0] set_in,
    input wire [W-1:0] clr_in,
    output wire [W-1:0] flags
);
    reg [W-1:0] flag_reg;
    genvar i;

    assign flags = flag_reg;

    generate
        for (i = 0; i < W; i = i + 1)
        begin : g_bit
            always @(posedge aclk)
            begin
                if (!aresetn)
                    flag_reg[i] <= 1'b0;
                else
                    flag_reg[i] <= set_in[i] | (flag_reg[i] & ~clr_in[i]);
            end
        end
    endgenerate
endmodule

// >>> logic/acmst_top.v
// audio clock monitor: clock checks, live and latched status, axi4-lite slave
// Notes on behaviour
// - bit 5 shows pll unlocked, also whenever the pll is disabled.
// - bit 6 shows master clock halted, 0 while it toggles.
// - bit 4 is 1 only when frame and bit clocks both sit low.
// - bit 3 flags a rate and master ratio pair autoset cannot handle.
// - bit 2 flags a master clock ratio that cannot be detected.
// - bit 2 also flags frame clock low phase of five bit clocks or fewer.
// - bit 1 is 0 only for a stable bit clock ratio of 32 to 256.
// - bit 0 flags a sampling rate that cannot be detected.
// - error ignore setting suppresses the sampling rate invalid flag.
// - latched halt bit 4 holds until a read of the register clears it.
// - second register bit 2 shows frame and bit clocks both missing.
// - second register bit 1 is high while resynchronisation runs.
// - latched error bit 0 sets when a clock error starts while none stands, clears on read.
//
// Design decision made here: register access over AXI4-Lite.
`include "acmst_map.vh"

module acmst_top (
    input wire aclk,
    input wire aresetn,
    input wire mclk_pin,
    input wire sclk_pin,
    input wire lrclk_pin,
    input wire pll_locked,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output wire irq
);
    // ----------------------------------------------------------------
    // timing counts
    // ----------------------------------------------------------------
    // worked out at full width, then cut on purpose to the counter widths
    localparam [31:0] MCLK_HALT_W =
        (`ACMST_MCLK_HALT_NS + `ACMST_CLK_NS - 1) / `ACMST_CLK_NS;
    localparam [31:0] SCLK_HALT_W =
        (`ACMST_SCLK_HALT_NS + `ACMST_CLK_NS - 1) / `ACMST_CLK_NS;
    localparam [31:0] LR_HALT_W =
        (`ACMST_LR_HALT_NS + `ACMST_CLK_NS - 1) / `ACMST_CLK_NS;
    localparam [31:0] FRAME_MIN_W =
        (`ACMST_FRAME_MIN_NS + `ACMST_CLK_NS - 1) / `ACMST_CLK_NS;
    localparam [31:0] FRAME_MAX_W = `ACMST_FRAME_MAX_NS / `ACMST_CLK_NS;
    localparam [12:0] MCLK_HALT_CYC = MCLK_HALT_W[12:0];
    localparam [12:0] SCLK_HALT_CYC = SCLK_HALT_W[12:0];
    localparam [12:0] LR_HALT_CYC = LR_HALT_W[12:0];
    localparam [11:0] FRAME_MIN_CYC = FRAME_MIN_W[11:0];
    localparam [11:0] FRAME_MAX_CYC = FRAME_MAX_W[11:0];

    // ----------------------------------------------------------------
    // pin watchers
    // ----------------------------------------------------------------
    wire mclk_rise;
    wire mclk_halted;
    wire sclk_level;
    wire sclk_rise;
    wire sclk_halted;
    wire lr_level;
    wire lr_rise;
    wire lr_fall;
    wire lr_halted;

    acmst_edge_watch #(.HALT_CYC(MCLK_HALT_CYC)) u_mclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(mclk_pin),
        .level(),
        .rise(mclk_rise),
        .fall(),
        .halted(mclk_halted)
    );

    acmst_edge_watch #(.HALT_CYC(SCLK_HALT_CYC)) u_sclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(sclk_pin),
        .level(sclk_level),
        .rise(sclk_rise),
        .fall(),
        .halted(sclk_halted)
    );

    acmst_edge_watch #(.HALT_CYC(LR_HALT_CYC)) u_lrclk (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(lrclk_pin),
        .level(lr_level),
        .rise(lr_rise),
        .fall(lr_fall),
        .halted(lr_halted)
    );

    // pll lock comes from the analog macro, so it is synchronised here
    reg lock_a_reg;
    reg lock_b_reg;

    // ----------------------------------------------------------------
    // per-frame measurement, restarted on each frame clock rise, low phase count on each fall
    // ----------------------------------------------------------------
    reg [11:0] frame_cnt_reg;
    reg [11:0] mclk_cnt_reg;
    reg [9:0] sclk_cnt_reg;
    reg [9:0] lrlow_cnt_reg;
    reg [11:0] frame_len_reg;
    reg [11:0] mclk_ratio_reg;
    reg [9:0] sclk_ratio_reg;
    reg [9:0] lrlow_len_reg;
    reg sclk_stable_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lock_a_reg <= 1'b0;
            lock_b_reg <= 1'b0;
            frame_cnt_reg <= 12'h000;
            mclk_cnt_reg <= 12'h000;
            sclk_cnt_reg <= 10'h000;
            lrlow_cnt_reg <= 10'h000;
            frame_len_reg <= 12'h000;
            mclk_ratio_reg <= 12'h000;
            sclk_ratio_reg <= 10'h000;
            lrlow_len_reg <= 10'h000;
            sclk_stable_reg <= 1'b0;
        end
        else
        begin
            lock_a_reg <= pll_locked;
            lock_b_reg <= lock_a_reg;
            if (lr_rise)
            begin
                frame_len_reg <= frame_cnt_reg;
                mclk_ratio_reg <= mclk_cnt_reg;
                sclk_ratio_reg <= sclk_cnt_reg;
                lrlow_len_reg <= lrlow_cnt_reg;
                sclk_stable_reg <= (sclk_cnt_reg == sclk_ratio_reg);
                frame_cnt_reg <= 12'h001;
                mclk_cnt_reg <= {11'h000, mclk_rise};
                sclk_cnt_reg <= {9'h000, sclk_rise};
            end
            else
            begin
                // saturate so a slow frame never wraps into a legal count
                if (frame_cnt_reg != 12'hfff)
                    frame_cnt_reg <= frame_cnt_reg + 12'h001;
                if (mclk_rise && mclk_cnt_reg != 12'hfff)
                    mclk_cnt_reg <= mclk_cnt_reg + 12'h001;
                if (sclk_rise && sclk_cnt_reg != 10'h3ff)
                    sclk_cnt_reg <= sclk_cnt_reg + 10'h001;
            end
            if (lr_fall)
                lrlow_cnt_reg <= 10'h000;
            else if (!lr_level && sclk_rise && lrlow_cnt_reg != 10'h3ff)
                lrlow_cnt_reg <= lrlow_cnt_reg + 10'h001;
        end
    end

    // master clock ratios that autoset recognises
    function ratio_known;
        input [11:0] r;
        begin
            case (r)
                12'h080, 12'h0c0, 12'h100, 12'h180, 12'h200, 12'h300,
                12'h400, 12'h480, 12'h600, 12'h800, 12'hc00: ratio_known = 1'b1;
                default: ratio_known = 1'b0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // control register and live conditions
    // ----------------------------------------------------------------
    reg [7:0] ctrl_reg;
    reg [6:0] live_reg;
    reg err_any_reg;
    reg [2:0] resync_cnt_reg;
    reg absent_prev_reg;
    reg halt_prev_reg;

    wire pll_unlocked = ~ctrl_reg[`ACMST_CT_PLL_EN] | ~lock_b_reg;
    wire absent = lr_halted & sclk_halted & ~lr_level & ~sclk_level;
    wire sr_bad = lr_halted | (frame_len_reg < FRAME_MIN_CYC) |
        (frame_len_reg > FRAME_MAX_CYC);
    wire mratio_bad = mclk_halted | lr_halted | ~ratio_known(mclk_ratio_reg);
    wire lrlow_short = lrlow_len_reg <= `ACMST_LRLOW_MAX_BAD;
    wire sclk_bad = sclk_halted | lr_halted | ~sclk_stable_reg |
        (sclk_ratio_reg < `ACMST_SCLK_RATIO_MIN) |
        (sclk_ratio_reg > `ACMST_SCLK_RATIO_MAX);

    reg [6:0] live_next;
    always @*
    begin
        live_next = 7'h00;
        live_next[`ACMST_LV_MCLK_HALT] = mclk_halted;
        live_next[`ACMST_LV_PLL_UNLOCK] = pll_unlocked;
        live_next[`ACMST_LV_ABSENT] = absent;
        live_next[`ACMST_LV_COMBO] = sr_bad | mratio_bad;
        live_next[`ACMST_LV_MCLK_INV] = mratio_bad | lrlow_short;
        live_next[`ACMST_LV_SCLK_INV] = sclk_bad;
        // an ignored error lets the converter run on, so it is not shown
        live_next[`ACMST_LV_SR_INV] = sr_bad & ~ctrl_reg[`ACMST_CT_ERR_IGNORE];
    end

    wire err_any = |live_next;
    wire err_event = err_any & ~err_any_reg;
    wire halt_event = mclk_halted & ~halt_prev_reg;
    wire absent_event = absent & ~absent_prev_reg;
    wire resync_busy = resync_cnt_reg != 3'h0;
    wire resync_done = lr_rise & ~err_any & (resync_cnt_reg == 3'h1);

    // live bits only ever follow their conditions, never the bus
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            live_reg <= 7'h00;
            err_any_reg <= 1'b0;
            halt_prev_reg <= 1'b0;
            absent_prev_reg <= 1'b0;
            resync_cnt_reg <= `ACMST_RESYNC_FRAMES;
        end
        else
        begin
            live_reg <= live_next;
            err_any_reg <= err_any;
            halt_prev_reg <= mclk_halted;
            absent_prev_reg <= absent;
            // resync re-arms on any error and runs down over clean frames
            if (err_any)
                resync_cnt_reg <= `ACMST_RESYNC_FRAMES;
            else if (lr_rise && resync_busy)
                resync_cnt_reg <= resync_cnt_reg - 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    reg aw_held_reg;
    reg [7:0] aw_idx_reg;
    reg aw_ok_reg;
    reg w_held_reg;
    reg [7:0] w_data_reg;
    reg w_lane_reg;
    reg bvalid_reg;
    reg [1:0] bresp_reg;
    reg rvalid_reg;
    reg [7:0] rdata_reg;
    reg [1:0] rresp_reg;
    reg [7:0] imask_reg;
    reg irq_reg;

    wire aw_take = s_axi_awvalid & ~aw_held_reg & ~bvalid_reg;
    wire w_take = s_axi_wvalid & ~w_held_reg & ~bvalid_reg;
    wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire ar_take = s_axi_arvalid & ~rvalid_reg;
    wire [7:0] ar_idx = s_axi_araddr[`ACMST_IDX_HI:`ACMST_IDX_LO];
    wire ar_ok = (s_axi_araddr[11:10] == 2'h0) & (s_axi_araddr[1:0] == 2'h0);
    wire [7:0] aw_idx = s_axi_awaddr[`ACMST_IDX_HI:`ACMST_IDX_LO];
    wire aw_ok = (s_axi_awaddr[11:10] == 2'h0) & (s_axi_awaddr[1:0] == 2'h0);

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};
    assign irq = irq_reg;

    // ----------------------------------------------------------------
    // latched flags and interrupt status
    // ----------------------------------------------------------------
    wire [7:0] latch_flags;
    wire [7:0] istat_flags;
    wire rd_latch = ar_take & ar_ok & (ar_idx == `ACMST_IDX_LATCH);
    wire wr_istat = do_write & aw_ok_reg & w_lane_reg &
        (aw_idx_reg == `ACMST_IDX_ISTAT);

    reg [7:0] latch_set;
    reg [7:0] event_vec;
    always @*
    begin
        latch_set = `ACMST_ZERO8;
        latch_set[`ACMST_LT_HALT] = halt_event;
        latch_set[`ACMST_LT_ERROR] = err_event;
        event_vec = latch_set;
        event_vec[`ACMST_LT_MISSING] = absent_event;
        event_vec[`ACMST_LT_RESYNC] = resync_done;
    end

    // the reading cycle captures the flags before they clear
    acmst_sticky #(.W(8)) u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(latch_set),
        .clr_in({8{rd_latch}}),
        .flags(latch_flags)
    );

    acmst_sticky #(.W(8)) u_istat (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_in(event_vec),
        .clr_in(wr_istat ? w_data_reg : `ACMST_ZERO8),
        .flags(istat_flags)
    );

    reg [7:0] latch_view;
    reg [7:0] rd_mux;
    reg rd_hit;
    always @*
    begin
        latch_view = `ACMST_ZERO8;
        latch_view[`ACMST_LT_HALT] = latch_flags[`ACMST_LT_HALT];
        latch_view[`ACMST_LT_MISSING] = live_reg[`ACMST_LV_ABSENT];
        latch_view[`ACMST_LT_RESYNC] = resync_busy;
        latch_view[`ACMST_LT_ERROR] = latch_flags[`ACMST_LT_ERROR];
        rd_hit = ar_ok;
        case (ar_idx)
            `ACMST_IDX_LIVE: rd_mux = {1'b0, live_reg};
            `ACMST_IDX_LATCH: rd_mux = latch_view;
            `ACMST_IDX_CTRL: rd_mux = ctrl_reg;
            `ACMST_IDX_ISTAT: rd_mux = istat_flags;
            `ACMST_IDX_IMASK: rd_mux = imask_reg;
            default:
            begin
                rd_mux = `ACMST_ZERO8;
                rd_hit = 1'b0;
            end
        endcase
        if (!ar_ok)
            rd_mux = `ACMST_ZERO8;
    end

    reg wr_hit;
    always @*
    begin
        case (aw_idx_reg)
            `ACMST_IDX_LIVE, `ACMST_IDX_LATCH, `ACMST_IDX_CTRL,
            `ACMST_IDX_ISTAT, `ACMST_IDX_IMASK: wr_hit = aw_ok_reg;
            default: wr_hit = 1'b0;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_idx_reg <= `ACMST_ZERO8;
            aw_ok_reg <= 1'b0;
            w_held_reg <= 1'b0;
            w_data_reg <= `ACMST_ZERO8;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ACMST_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= `ACMST_ZERO8;
            rresp_reg <= `ACMST_RESP_OKAY;
            ctrl_reg <= `ACMST_CTRL_RST;
            imask_reg <= `ACMST_ZERO8;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(istat_flags & imask_reg);
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                aw_idx_reg <= aw_idx;
                aw_ok_reg <= aw_ok;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? `ACMST_RESP_OKAY : `ACMST_RESP_SLVERR;
                // live and latched registers ignore writes; only byte lane 0 carries data
                if (wr_hit && w_lane_reg)
                begin
                    if (aw_idx_reg == `ACMST_IDX_CTRL)
                        ctrl_reg <= w_data_reg;
                    if (aw_idx_reg == `ACMST_IDX_IMASK)
                        imask_reg <= w_data_reg;
                end
            end
            else if (bvalid_reg && s_axi_bready)
                bvalid_reg <= 1'b0;
            if (ar_take)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? `ACMST_RESP_OKAY : `ACMST_RESP_SLVERR;
            end
            else if (rvalid_reg && s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end
endmodule

// >>> test/acmst_clk_src.sv
// behavioural source of the master, bit and frame clocks
module acmst_clk_src (
    input logic mclk_on,
    input logic ser_on,
    input logic short_low,
    output logic mclk_pin,
    output logic sclk_pin,
    output logic lrclk_pin
);
timeunit 1ns;
timeprecision 1ps;
logic [5:0] bit_cnt;
// ----------------------------------------------------------------
// 64 bit clocks and 128 master clocks per frame
// ----------------------------------------------------------------
initial
begin
    mclk_pin = 1'b0;
    sclk_pin = 1'b0;
    lrclk_pin = 1'b0;
    bit_cnt = 6'h00;
end
// stopped clocks sit low, as a tied-off source would
always #80 mclk_pin = mclk_on & ~mclk_pin;
// frame clock moves on the falling bit clock edge
always #160
begin
    sclk_pin = ser_on & ~sclk_pin;
    if (!ser_on)
        bit_cnt = 6'h00;
    else if (!sclk_pin)
        bit_cnt = bit_cnt + 6'h01;
    lrclk_pin = ser_on && bit_cnt >= (short_low ? 6'h04 : 6'h20);
end
endmodule

// >>> test/acmst_checker.sv
// concurrent checks on the clock monitor ports
module acmst_checker (
    input wire aclk,
    input wire aresetn,
    input wire mclk_pin,
    input wire sclk_pin,
    input wire lrclk_pin,
    input wire pll_locked,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid
);
timeunit 1ns;
timeprecision 1ps;
logic [11:0] mclk_still_reg, ser_low_reg, pll_low_reg;
logic mclk_prev_reg;
logic rd_live, rd_flag;
// ----------------------------------------------------------------
// how long each pin has been quiet, saturating
// ----------------------------------------------------------------
assign rd_live = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h178;
assign rd_flag = s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h17c;
always @(posedge aclk)
begin
    mclk_prev_reg <= mclk_pin;
    mclk_still_reg <= (!aresetn || mclk_pin != mclk_prev_reg) ? 12'h000
        : mclk_still_reg + {11'h000, ~&mclk_still_reg};
    ser_low_reg <= (!aresetn || sclk_pin || lrclk_pin) ? 12'h000
        : ser_low_reg + {11'h000, ~&ser_low_reg};
    pll_low_reg <= (!aresetn || pll_locked) ? 12'h000 : pll_low_reg + {11'h000, ~&pll_low_reg};
end
// ----------------------------------------------------------------
// assertions
// ----------------------------------------------------------------
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
a_bad_addr: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[1:0] != 2'h0
    || s_axi_araddr < 12'h178 || s_axi_araddr > 12'h188)
    |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000) else $error("bad address accepted");
a_pll_unlock: assert property (
    rd_live && pll_low_reg >= 12'h008 |=> s_axi_rdata[5]) else $error("pll unlock not shown");
a_mclk_halt: assert property (
    rd_live && mclk_still_reg >= 12'h050 |=> s_axi_rdata[6]) else $error("halt not shown");
a_ser_absent: assert property (
    rd_live && ser_low_reg >= 12'hb00 |=> s_axi_rdata[4]) else $error("absence not shown");
a_ser_missing: assert property (
    rd_flag && ser_low_reg >= 12'hb00 |=> s_axi_rdata[2]) else $error("missing not shown");
endmodule
bind acmst_top acmst_checker chk (
    .aclk, .aresetn, .mclk_pin, .sclk_pin, .lrclk_pin, .pll_locked,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid
);

// >>> test/tb_audio_clock_monitor_status.sv
// self-checking bench for the audio clock monitor
module tb_audio_clock_monitor_status;
timeunit 1ns;
timeprecision 1ps;
logic aclk, aresetn, mclk_pin, sclk_pin, lrclk_pin, pll_locked, irq;
logic mclk_on, ser_on, short_low;
logic [11:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata, got;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
int fails, checks, cyc;
// {mclk_on, ser_on, short_low, pll_locked}, ctrl, expected live, compare mask;
// a short frame low phase leaves rate and ratio valid, so combo stays clear
logic [27:0] rows [7] = '{28'hd0200ff, 28'hc0220ff, 28'hd0020ff, 28'h5024cff,
    28'hf0204ff, 28'h9021fff, 28'h9031eff};
acmst_top dut (
    .aclk, .aresetn, .mclk_pin, .sclk_pin, .lrclk_pin, .pll_locked,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq
);
acmst_clk_src src (.mclk_on, .ser_on, .short_low, .mclk_pin, .sclk_pin, .lrclk_pin);
// ----------------------------------------------------------------
// clock, timeout and bus tasks
// ----------------------------------------------------------------
initial
begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
end
always @(posedge aclk)
begin
    cyc++;
    if (cyc == 40000)
    begin
        fails++;
        conclude();
    end
end
task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want)
    begin
        fails++;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
endtask
// no wait limit here: the cycle ceiling cuts a hung handshake
task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    got = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
task automatic irq_is(input logic v);
    repeat (4) @(posedge aclk);
    chk({31'h00000000, irq}, {31'h00000000, v});
endtask
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial
begin
    aresetn = 1'b0;
    {mclk_on, ser_on, short_low, pll_locked} = 4'hd;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h180);
    chk(got, 32'h00000002);
    rd(12'h188);
    chk(got, 32'h00000000);
    rd(12'h200);
    chk({got[31:2], rsp}, 32'h00000002);
    wr(12'h178, 8'hff);
    chk({30'h00000000, rsp}, 32'h00000000);
    // byte lane 0 not strobed: the write is answered but changes nothing
    s_axi_wstrb <= 4'he;
    wr(12'h180, 8'h00);
    chk({30'h00000000, rsp}, 32'h00000000);
    s_axi_wstrb <= 4'hf;
    rd(12'h180);
    chk(got, 32'h00000002);
    foreach (rows[i])
    begin
        @(posedge aclk);
        {mclk_on, ser_on, short_low, pll_locked} <= rows[i][27:24];
        wr(12'h180, rows[i][23:16]);
        repeat (3500) @(posedge aclk);
        rd(12'h178);
        chk(got & {24'h000000, rows[i][7:0]}, {24'h000000, rows[i][15:8]});
    end
    // halt and error stay latched until read; the clearing read still shows them
    rd(12'h17c);
    chk(got, 32'h00000017);
    rd(12'h17c);
    chk(got, 32'h00000006);
    @(posedge aclk);
    ser_on <= 1'b1;
    wr(12'h180, 8'h02);
    repeat (3500) @(posedge aclk);
    rd(12'h17c);
    chk(got & 32'h00000016, 32'h00000000);
    rd(12'h178);
    chk(got, 32'h00000000);
    rd(12'h178);
    chk(got, 32'h00000000);
    wr(12'h188, 8'h01);
    wr(12'h184, 8'h17);
    irq_is(1'b0);
    @(posedge aclk);
    mclk_on <= 1'b0;
    repeat (120) @(posedge aclk);
    chk({31'h00000000, irq}, 32'h00000001);
    wr(12'h188, 8'h00);
    irq_is(1'b0);
    wr(12'h188, 8'h01);
    irq_is(1'b1);
    wr(12'h184, 8'h01);
    irq_is(1'b0);
    rd(12'h17c);
    chk(got & 32'h00000011, 32'h00000011);
    conclude();
end
endmodule
